// ---- cra_target.sv ----
// Configuration register access target: decodes framed write and read
// requests, performs the register access and returns the reply tokens.
// Assumes the token link and the register port run on clk.
`timescale 1ns/1ps
`include "cra_defines.svh"
module cra_target (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         periph_byte,  // Peripheral access width is 8 bits
  input  wire logic         rx_valid,
  input  wire logic         rx_ctrl,
  input  wire logic [7:0]   rx_data,
  output logic              rx_ready,
  output logic              tx_valid,
  output logic              tx_ctrl,
  output logic [7:0]        tx_data,
  input  wire logic         tx_ready,
  output logic [23:0]       reply_dest,   // Channel end that receives the reply
  output logic              reg_req,
  output logic              reg_we,
  output logic [15:0]       reg_addr,
  output logic [31:0]       reg_wdata,
  output logic              reg_byte,     // Access is 8 bits wide
  input  wire logic         reg_ack,
  input  wire logic         reg_ok,       // Register exists and access succeeded
  input  wire logic [31:0]  reg_rdata
);
  logic             rst_meta;
  logic             rst_n;
  cra_pkg::cra_rx_e state;
  logic [2:0]       cnt;
  logic             rid_full;
  logic             acc_ok;
  logic [31:0]      rdata_q;
  logic             take;
  logic             is_end;
  logic             noreply;
  logic [2:0]       dbytes;
  cra_reply_if      rp ();

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Handshake terms
  assign rx_ready = (state == cra_pkg::RX_IDLE) || (state == cra_pkg::RX_RID)
                 || (state == cra_pkg::RX_REG) || (state == cra_pkg::RX_DATA)
                 || (state == cra_pkg::RX_END) || (state == cra_pkg::RX_SKIP);
  assign take     = rx_valid && rx_ready;
  assign is_end   = rx_ctrl && (rx_data == `CRA_TOK_END);
  assign noreply  = reg_we && (reply_dest[7:0] == `CRA_NOREPLY_LOW);
  assign dbytes   = reg_byte ? `CRA_BYTE_BYTES : `CRA_WORD_BYTES;
  assign reg_req  = (state == cra_pkg::RX_ACCESS);
  assign rp.start = (state == cra_pkg::RX_REPLY);
  assign rp.ok    = acc_ok;
  assign rp.nbytes = (acc_ok && !reg_we) ? dbytes : 3'h0;
  assign rp.rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Request decoder
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= cra_pkg::RX_IDLE;
      cnt        <= 3'h0;
      rid_full   <= 1'b0;
      reg_we     <= 1'b0;
      reg_byte   <= 1'b0;
      reply_dest <= 24'h00_0000;
      reg_addr   <= 16'h0000;
      reg_wdata  <= 32'h0000_0000;
      acc_ok     <= 1'b0;
      rdata_q    <= 32'h0000_0000;
    end else begin
      unique case (state)
        cra_pkg::RX_IDLE: begin
          if (take && rx_ctrl && (rx_data == `CRA_TOK_WRITE
                                  || rx_data == `CRA_TOK_READ)) begin
            state    <= cra_pkg::RX_RID;
            reg_we   <= (rx_data == `CRA_TOK_WRITE);
            reg_byte <= periph_byte;
            cnt      <= 3'h0;
            rid_full <= 1'b0;
            acc_ok   <= 1'b0;
          end
        end
        cra_pkg::RX_RID: begin
          if (take && rx_ctrl) begin
            state <= is_end ? cra_pkg::RX_IDLE : cra_pkg::RX_SKIP;
          end else if (take) begin
            reply_dest <= {reply_dest[15:0], rx_data};
            cnt        <= cnt + 3'h1;
            if (cnt == `CRA_RID_BYTES - 3'h1) begin
              state    <= cra_pkg::RX_REG;
              cnt      <= 3'h0;
              rid_full <= 1'b1;
            end
          end
        end
        cra_pkg::RX_REG: begin
          if (take && rx_ctrl) begin
            state <= is_end ? cra_pkg::RX_REPLY : cra_pkg::RX_SKIP;
            if (is_end && noreply) begin
              state <= cra_pkg::RX_IDLE;
            end
          end else if (take) begin
            reg_addr <= {reg_addr[7:0], rx_data};
            cnt      <= cnt + 3'h1;
            if (cnt == `CRA_REG_BYTES - 3'h1) begin
              state <= reg_we ? cra_pkg::RX_DATA : cra_pkg::RX_END;
              cnt   <= 3'h0;
            end
          end
        end
        cra_pkg::RX_DATA: begin
          if (take && rx_ctrl) begin
            state <= is_end ? cra_pkg::RX_REPLY : cra_pkg::RX_SKIP;
            if (is_end && noreply) begin
              state <= cra_pkg::RX_IDLE;
            end
          end else if (take) begin
            reg_wdata <= reg_byte ? {24'h00_0000, rx_data}
                                  : {reg_wdata[23:0], rx_data};
            cnt       <= cnt + 3'h1;
            if (cnt == dbytes - 3'h1) begin
              state <= cra_pkg::RX_END;
            end
          end
        end
        cra_pkg::RX_END: begin
          if (take && is_end) begin
            state <= cra_pkg::RX_ACCESS;
          end else if (take) begin
            state <= cra_pkg::RX_SKIP;
          end
        end
        cra_pkg::RX_SKIP: begin
          // Malformed request: drain to its end token, then fail if addressable
          if (take && is_end) begin
            state <= (rid_full && !noreply) ? cra_pkg::RX_REPLY
                                            : cra_pkg::RX_IDLE;
          end
        end
        cra_pkg::RX_ACCESS: begin
          if (reg_ack) begin
            acc_ok  <= reg_ok;
            rdata_q <= reg_byte ? {reg_rdata[7:0], 24'h00_0000} : reg_rdata;
            state   <= noreply ? cra_pkg::RX_IDLE : cra_pkg::RX_REPLY;
          end
        end
        cra_pkg::RX_REPLY: begin
          state <= cra_pkg::RX_WAIT;
        end
        cra_pkg::RX_WAIT: begin
          if (!rp.busy) begin
            state <= cra_pkg::RX_IDLE;
          end
        end
        // Unused state codes fall back to idle
        default: begin
          state <= cra_pkg::RX_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reply sender
  cra_reply u_reply (
    .clk      (clk),
    .rst_n    (rst_n),
    .rp       (rp.snd),
    .tx_valid (tx_valid),
    .tx_ctrl  (tx_ctrl),
    .tx_data  (tx_data),
    .tx_ready (tx_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_noreply_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    state == cra_pkg::RX_ACCESS && reg_ack && noreply
    |=> state == cra_pkg::RX_IDLE ##1 !tx_valid)
    else $error("reply sent for a suppressed write");
  a_reply_follows: assert property (@(posedge clk) disable iff (!rst_n)
    state == cra_pkg::RX_ACCESS && reg_ack && !noreply
    |=> state == cra_pkg::RX_REPLY ##1 tx_valid && tx_ctrl)
    else $error("access not followed by a reply");
  a_fail_kept: assert property (@(posedge clk) disable iff (!rst_n)
    state == cra_pkg::RX_ACCESS && reg_ack && !reg_ok |=> !acc_ok)
    else $error("failed access reported as success");
  a_rid_msb: assert property (@(posedge clk) disable iff (!rst_n)
    state == cra_pkg::RX_RID && take && !rx_ctrl
    |=> reply_dest[7:0] == $past(rx_data) && reply_dest[15:8] == $past(reply_dest[7:0]))
    else $error("return identifier not shifted in most significant first");
  a_end_access: assert property (@(posedge clk) disable iff (!rst_n)
    state == cra_pkg::RX_END && take && is_end |=> reg_req)
    else $error("closing token did not start the access");
  a_read_head: assert property (@(posedge clk) disable iff (!rst_n)
    state == cra_pkg::RX_IDLE && take && rx_ctrl && rx_data == `CRA_TOK_READ
    |=> state == cra_pkg::RX_RID && !reg_we)
    else $error("read header not decoded");
endmodule

// ---- cra_defines.svh ----
// Constants for the configuration register access target.
// Assumes a byte-wide token link where each byte is flagged as control or data.
//
// Behaviour
// - A write whose return identifier ends in 0xFF gets no reply.
// - Multi-byte fields travel most significant byte first, both directions.
// - Write request: token 192, return id, 16-bit register, access-width data (32 or 8 bits), token 1.
// - Read request: token 193, return id, 16-bit register, token 1.
// - Write reply is tokens 3 and 1 on success, 4 and 1 on failure.
// - Configuration read reply: token 3, 32 data bits, token 1; else 4, 1.
// - Peripheral read reply: token 3, access-width data, token 1; else 4, 1.
`ifndef CRA_DEFINES_SVH
`define CRA_DEFINES_SVH

`define CRA_TOK_WRITE   8'hC0
`define CRA_TOK_READ    8'hC1
`define CRA_TOK_END     8'h01
`define CRA_TOK_ACK     8'h03
`define CRA_TOK_NACK    8'h04
`define CRA_NOREPLY_LOW 8'hFF
`define CRA_RID_BYTES   3'h3
`define CRA_REG_BYTES   3'h2
`define CRA_WORD_BYTES  3'h4
`define CRA_BYTE_BYTES  3'h1
`define CRA_PS_SHIFT    8
`define CRA_PS_TYPE     8'h0B

`endif

// ---- cra_pkg.sv ----
// Types shared by the access target and its reply sender.
// Assumes nothing beyond a SystemVerilog compiler.
package cra_pkg;
  typedef enum logic [3:0] {RX_IDLE, RX_RID, RX_REG, RX_DATA, RX_END, RX_SKIP,
                            RX_ACCESS, RX_REPLY, RX_WAIT} cra_rx_e;
  typedef enum logic [1:0] {TX_IDLE, TX_HEAD, TX_DATA, TX_END} cra_tx_e;
endpackage

// ---- cra_reply_if.sv ----
// Carrier between the request decoder and the reply sender.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface cra_reply_if;
  logic        start;   // One-cycle request to send a reply
  logic        ok;      // Success or failure reply
  logic [2:0]  nbytes;  // Data bytes to send after the success token
  logic [31:0] rdata;   // Read data, first byte in bits 31:24
  logic        busy;    // Sender is emitting a reply
  modport dec (output start, output ok, output nbytes, output rdata, input busy);
  modport snd (input start, input ok, input nbytes, input rdata, output busy);
endinterface

// ---- cra_reply.sv ----
// Reply sender: emits success or failure token sequences with read data.
// Assumes tx_ready comes from logic on the same clock.
`timescale 1ns/1ps
`include "cra_defines.svh"
module cra_reply (
  input  wire logic  clk,
  input  wire logic  rst_n,
  cra_reply_if.snd   rp,
  output logic       tx_valid,
  output logic       tx_ctrl,
  output logic [7:0] tx_data,
  input  wire logic  tx_ready
);
  cra_pkg::cra_tx_e state;
  logic [2:0]       remain;
  logic [31:0]      shreg;

  assign rp.busy = (state != cra_pkg::TX_IDLE);

  // Token sequencer, one byte per accepted transfer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= cra_pkg::TX_IDLE;
      remain   <= 3'h0;
      shreg    <= 32'h0000_0000;
      tx_valid <= 1'b0;
      tx_ctrl  <= 1'b0;
      tx_data  <= 8'h00;
    end else begin
      unique case (state)
        cra_pkg::TX_IDLE: begin
          if (rp.start) begin
            state    <= cra_pkg::TX_HEAD;
            remain   <= rp.ok ? rp.nbytes : 3'h0;
            shreg    <= rp.rdata;
            tx_valid <= 1'b1;
            tx_ctrl  <= 1'b1;
            tx_data  <= rp.ok ? `CRA_TOK_ACK : `CRA_TOK_NACK;
          end
        end
        cra_pkg::TX_HEAD, cra_pkg::TX_DATA: begin
          if (tx_ready) begin
            if (remain != 3'h0) begin
              state   <= cra_pkg::TX_DATA;
              tx_ctrl <= 1'b0;
              tx_data <= shreg[31:24];
              shreg   <= {shreg[23:0], 8'h00};
              remain  <= remain - 3'h1;
            end else begin
              state   <= cra_pkg::TX_END;
              tx_ctrl <= 1'b1;
              tx_data <= `CRA_TOK_END;
            end
          end
        end
        cra_pkg::TX_END: begin
          if (tx_ready) begin
            state    <= cra_pkg::TX_IDLE;
            tx_valid <= 1'b0;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_ack_first: assert property (@(posedge clk) disable iff (!rst_n)
    state == cra_pkg::TX_IDLE && rp.start && rp.ok
    |=> tx_valid && tx_ctrl && tx_data == `CRA_TOK_ACK)
    else $error("success reply does not open with token 3");
  a_nack_first: assert property (@(posedge clk) disable iff (!rst_n)
    state == cra_pkg::TX_IDLE && rp.start && !rp.ok
    |=> tx_valid && tx_ctrl && tx_data == `CRA_TOK_NACK)
    else $error("failure reply does not open with token 4");
  a_nack_close: assert property (@(posedge clk) disable iff (!rst_n)
    state == cra_pkg::TX_HEAD && tx_ctrl && tx_data == `CRA_TOK_NACK && tx_ready
    |=> tx_valid && tx_ctrl && tx_data == `CRA_TOK_END)
    else $error("failure token not followed by token 1");
  a_end_close: assert property (@(posedge clk) disable iff (!rst_n)
    state == cra_pkg::TX_END |-> tx_valid && tx_ctrl && tx_data == `CRA_TOK_END)
    else $error("reply not closed by token 1");
  a_data_count: assert property (@(posedge clk) disable iff (!rst_n)
    state == cra_pkg::TX_HEAD && tx_ready && remain == `CRA_WORD_BYTES
    |=> !tx_ctrl && remain == 3'h3)
    else $error("word read reply does not start its four data bytes");
endmodule

// ---- cra_req_model.sv ----
// Requesting channel end: frames write and read requests, takes reply bytes.
// Assumes its tasks are called at a falling clock edge.
`timescale 1ns/1ps
module cra_req_model (
  input  wire logic       clk,
  input  wire logic       rdy_rnd,   // Stall pattern from the bench
  output logic            rx_valid,
  output logic            rx_ctrl,
  output logic [7:0]      rx_data,
  input  wire logic       rx_ready,
  output logic            tx_ready
);
  logic [31:0]            dest;      // Channel-end destination for the addressed target
  logic [23:0]            ps_id;     // Status resource id for the register number
  ////////////////////////////////////////////////////////////////////////////////
  // Idle link at time zero
  initial begin
    rx_valid = 1'h0;
    rx_ctrl  = 1'h0;
    rx_data  = 8'hA5;
  end

  // Reply bytes are taken promptly or slowly
  always @(negedge clk) tx_ready <= rdy_rnd;

  ////////////////////////////////////////////////////////////////////////////////
  // One byte, held until sampled with the ready flag high
  task automatic send(input logic c, input logic [7:0] d);
    rx_valid = 1'h1;
    rx_ctrl  = c;
    rx_data  = d;
    do @(posedge clk); while (rx_ready !== 1'h1);
    @(negedge clk);
  endtask

  // Released link shows no stale byte
  task automatic release_link();
    rx_valid = 1'h0;
    rx_ctrl  = ~rx_ctrl;
    rx_data  = ~rx_data;
  endtask

  // Whole request; bad 1 adds a stray data byte, bad 2 cuts the return id short
  task automatic request(input logic wr, input logic b8, input logic [23:0] rid,
                         input logic [15:0] ra, input logic [31:0] wd, input int bad);
    int n;
    n = b8 ? 1 : 4;
    // Peripheral 1 for byte access, else tile or node by the id's low bit
    dest  = b8 ? {rid[23:8], 8'h01, 8'h02}
               : {rid[23:8], rid[0] ? 16'hC20C : 16'hC30C};
    ps_id = ({8'h00, ra} << 8) | 24'h00000B;
    send(1'h1, wr ? 8'hC0 : 8'hC1);
    if (bad == 2) begin
      send(1'h0, rid[23:16]);
    end else begin
      for (int i = 2; i >= 0; i--) send(1'h0, rid[8*i+:8]);
      for (int i = 1; i >= 0; i--) send(1'h0, ra[8*i+:8]);
      if (wr) for (int i = n - 1; i >= 0; i--) send(1'h0, wd[8*i+:8]);
      if (bad == 1) send(1'h0, 8'h5A);
    end
    send(1'h1, 8'h01);
    release_link();
  endtask
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the configuration register access target.
// Assumes cra_req_model stands in for the requester; the bench answers registers.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((e) !== (g)) begin fail_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb_top;
  logic        clk, reset_n, periph_byte, rdy_rnd, rx_valid, rx_ctrl, rx_ready;
  logic        tx_valid, tx_ctrl, tx_ready, reg_req, reg_we, reg_byte, reg_ack, reg_ok;
  logic [7:0]  rx_data, tx_data;
  logic [23:0] reply_dest, e_rid;
  logic [15:0] reg_addr, e_ra;
  logic [31:0] reg_wdata, reg_rdata, e_wd, e_rd, r, a, b;
  logic [8:0]  got, exp_q[$];
  logic        e_we, e_b8, e_ok;
  int          seed, checks, fail_count, acc_n, e_acc;

  cra_req_model req_u (.clk(clk), .rdy_rnd(rdy_rnd), .rx_valid(rx_valid), .rx_ctrl(rx_ctrl),
    .rx_data(rx_data), .rx_ready(rx_ready), .tx_ready(tx_ready));
  cra_target dut_u (.clk(clk), .reset_n(reset_n), .periph_byte(periph_byte),
    .rx_valid(rx_valid), .rx_ctrl(rx_ctrl), .rx_data(rx_data), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_ctrl(tx_ctrl), .tx_data(tx_data), .tx_ready(tx_ready),
    .reply_dest(reply_dest), .reg_req(reg_req), .reg_we(reg_we), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_byte(reg_byte), .reg_ack(reg_ack), .reg_ok(reg_ok),
    .reg_rdata(reg_rdata));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and random stalls on the reply side
  initial clk = 1'h0;
  always #5 clk = ~clk;
  always @(negedge clk) rdy_rnd <= ($random(seed) & 3) != 0;

  // Reply watcher: every byte taken is matched against the oldest note
  always @(posedge clk) begin
    if (tx_valid === 1'h1 && tx_ready === 1'h1) begin
      got = exp_q.size() ? exp_q.pop_front() : 9'hXXX;
      `CHK("reply byte", got, {tx_ctrl, tx_data})
    end
  end

  // Register port answers after a random latency
  initial begin
    reg_ack   = 1'h0;
    reg_ok    = 1'h0;
    reg_rdata = 32'h0;
    forever begin
      @(negedge clk);
      if (reg_req === 1'h1) begin
        acc_n++;
        `CHK("write flag", e_we, reg_we)
        `CHK("register number", e_ra, reg_addr)
        `CHK("access width", e_b8, reg_byte)
        `CHK("return id", e_rid, reply_dest)
        if (e_we) `CHK("write data", e_wd, reg_wdata)
        repeat ($random(seed) & 3) @(negedge clk);
        reg_ack   = 1'h1;
        reg_ok    = e_ok;
        reg_rdata = e_rd;
        @(negedge clk);
        reg_ack   = 1'h0;
        reg_rdata = ~e_rd;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One request with its expected accesses and reply notes
  task automatic run(input logic wr, input logic b8, input logic [23:0] rid,
                     input logic [15:0] ra, input logic [31:0] wd, input logic ok,
                     input logic [31:0] rd, input int bad);
    int k;
    int n;
    n = b8 ? 1 : 4;
    e_we = wr;
    e_ra = ra;
    e_b8 = b8;
    e_rid = rid;
    e_ok = ok;
    e_rd = rd;
    e_wd = b8 ? {24'h0, wd[7:0]} : wd;
    if (bad == 0) e_acc++;
    if (bad == 2 || (wr && rid[7:0] == 8'hFF)) begin
      k = 0;
    end else if (bad == 1 || !ok) begin
      exp_q.push_back(9'h104);
      exp_q.push_back(9'h101);
    end else begin
      exp_q.push_back(9'h103);
      if (!wr) for (int i = n - 1; i >= 0; i--) exp_q.push_back({1'h0, rd[8*i+:8]});
      exp_q.push_back(9'h101);
    end
    periph_byte = b8;
    req_u.request(wr, b8, rid, ra, wd, bad);
    `CHK("destination", {rid[23:8], b8 ? 16'h0102 : (rid[0] ? 16'hC20C : 16'hC30C)}, req_u.dest)
    `CHK("status resource id", {ra, 8'h0B}, req_u.ps_id)
    k = 0;
    while (k < 300 && !(exp_q.size() == 0 && rx_ready === 1'h1 && tx_valid === 1'h0)) begin
      @(negedge clk);
      k++;
    end
    `CHK("reply finished", 1'h1, k < 300)
    `CHK("access count", e_acc, acc_n)
  endtask

  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    fail_count++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    seed = 32'h51E05B45;
    reset_n = 1'h0;
    periph_byte = 1'h0;
    repeat (4) @(negedge clk);
    reset_n = 1'h1;
    repeat (3) @(negedge clk);
    run(1'h1, 1'h0, 24'h123456, 16'hA55A, 32'hDEADBEEF, 1'h1, 32'h0, 0);
    run(1'h0, 1'h0, 24'h654321, 16'h0102, 32'h0, 1'h1, 32'h89ABCDEF, 0);
    run(1'h1, 1'h0, 24'h111111, 16'hFFFF, 32'h1, 1'h0, 32'h0, 0);
    run(1'h0, 1'h0, 24'h222222, 16'h8000, 32'h0, 1'h0, 32'h5, 0);
    run(1'h1, 1'h0, 24'h0A0BFF, 16'h0003, 32'hCAFE0001, 1'h1, 32'h0, 0);
    run(1'h0, 1'h0, 24'h0A0BFF, 16'h0004, 32'h0, 1'h1, 32'h01020304, 0);
    run(1'h1, 1'h1, 24'h333333, 16'h0010, 32'h777777C3, 1'h1, 32'h0, 0);
    run(1'h0, 1'h1, 24'h444444, 16'h0011, 32'h0, 1'h1, 32'hABCDEF96, 0);
    run(1'h0, 1'h1, 24'h555555, 16'h0012, 32'h0, 1'h0, 32'h0, 0);
    req_u.send(1'h0, 8'hC1);
    req_u.release_link();
    run(1'h1, 1'h0, 24'h666666, 16'h0020, 32'h12345678, 1'h1, 32'h0, 1);
    run(1'h0, 1'h0, 24'h777777, 16'h0021, 32'h0, 1'h1, 32'h0, 1);
    run(1'h1, 1'h0, 24'h8888FF, 16'h0022, 32'h0, 1'h1, 32'h0, 1);
    run(1'h0, 1'h0, 24'h999999, 16'h0023, 32'h0, 1'h1, 32'h0, 2);
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      a = $random(seed);
      b = $random(seed);
      run(r[0], r[1], a[23:0], r[31:16], a, r[2] | r[3], b, 0);
    end
    test_done();
  end
endmodule
